//--- cims_pkg.sv
// Constants and types for the power-on initialization and mode select block.
// Assumes a single 50 MHz system clock; no register bus.
package cims_pkg;
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned TIMER_HZ = 1_000_000;
    localparam int unsigned TIMER_DIV = SYS_CLK_HZ / TIMER_HZ;
    localparam int unsigned INIT_CNT_W = 14;
    localparam int unsigned MASTER_PASSES = 4;
    localparam int unsigned CLEAR_CYCLES = 64;
    typedef enum logic [2:0] {
        CIMS_MODE_MASTER_SERIAL,
        CIMS_MODE_MASTER_UP,
        CIMS_MODE_MASTER_DOWN,
        CIMS_MODE_PERIPHERAL,
        CIMS_MODE_SLAVE,
        CIMS_MODE_UNDEFINED
    } cims_mode_e;
    typedef enum logic [2:0] {
        CIMS_ST_INIT,
        CIMS_ST_CLEAR,
        CIMS_ST_WAIT_RESET,
        CIMS_ST_CONFIG,
        CIMS_ST_RUN
    } cims_state_e;
endpackage

//--- cims_osc_ctrl.sv
// Crystal oscillator gating and optional divide-by-two.
// Assumes the amplifier output is already synchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none
module cims_osc_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_osc_enable,
    input wire logic i_osc_div2,
    input wire logic i_osc_amp,
    input wire logic i_config_done,
    output logic o_osc_run,
    output logic o_osc_clk,
    output logic o_osc_io_user
);
    logic div_q;
    logic clk_q;
    logic amp_q;
    assign o_osc_run = i_osc_enable;
    assign o_osc_io_user = !i_osc_enable;

    // Rising edges only, so a wide high phase toggles once
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            amp_q <= 1'b0;
        end else begin
            amp_q <= i_osc_amp;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_q <= 1'b0;
        end else if (i_osc_enable && i_osc_amp && !amp_q) begin
            div_q <= !div_q;
        end
    end

    // Held low until configuration so no half-loaded logic sees edges
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= i_osc_enable && i_config_done && (i_osc_div2 ? div_q : i_osc_amp);
        end
    end
    assign o_osc_clk = clk_q;

    chk_osc_gated: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !$past(i_config_done) |-> !o_osc_clk)
        else $error("oscillator reached logic before configuration done");
endmodule
`default_nettype wire

//--- cims_top.sv
// Power-on initialization, clear and mode selection sequencer.
// Assumes synchronous pin inputs and one 50 MHz clock; reset is power-on.
`timescale 1ns/10ps
`default_nettype none
module cims_top #(
    parameter int unsigned INIT_CNT_W = cims_pkg::INIT_CNT_W,
    parameter int unsigned TIMER_DIV = cims_pkg::TIMER_DIV,
    parameter int unsigned CLEAR_CYCLES = cims_pkg::CLEAR_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_ext_reset_n,
    input wire logic i_mode_select_pin_0,
    input wire logic i_mode_select_pin_1,
    input wire logic i_mode_select_pin_2,
    input wire logic i_powerdown_req,
    input wire logic i_config_clock_in,
    input wire logic i_config_loaded,
    input wire logic i_osc_enable,
    input wire logic i_osc_div2,
    input wire logic i_osc_amp,
    output logic o_user_out_disable,
    output logic o_user_pullup,
    output logic o_powerdown,
    output logic o_clear_mem,
    output logic o_init_ready_n_o,
    output logic o_init_ready_n_oe,
    output cims_pkg::cims_mode_e o_mode,
    output logic o_config_clock_oe,
    output logic o_config_clock_o,
    output logic o_config_active,
    output logic o_config_done,
    output logic o_osc_run,
    output logic o_osc_clk,
    output logic o_osc_io_user
);
    import cims_pkg::*;

    localparam int unsigned TICK_W = $clog2(TIMER_DIV);
    localparam int unsigned CLR_W = $clog2(CLEAR_CYCLES + 1);

    cims_state_e state_q;
    cims_mode_e mode_q;
    cims_mode_e mode_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick;
    logic [INIT_CNT_W-1:0] init_cnt_q;
    logic [1:0] pass_q;
    logic [CLR_W-1:0] clr_cnt_q;
    logic is_master;
    logic timeout_done;
    logic config_clock_q;
    logic pd_q;
    int unsigned tick_gap_q;

    // Pin order 0,1,2 forms the code
    always_comb begin
        unique case ({i_mode_select_pin_0, i_mode_select_pin_1, i_mode_select_pin_2})
            3'h0: mode_d = CIMS_MODE_MASTER_SERIAL;
            3'h1: mode_d = CIMS_MODE_MASTER_UP;
            3'h3: mode_d = CIMS_MODE_MASTER_DOWN;
            3'h5: mode_d = CIMS_MODE_PERIPHERAL;
            3'h7: mode_d = CIMS_MODE_SLAVE;
            default: mode_d = CIMS_MODE_UNDEFINED;
        endcase
    end

    // Pins are watched live through init, clear and reset wait; frozen once configuration starts
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q <= CIMS_MODE_UNDEFINED;
        end else if (state_q != CIMS_ST_CONFIG && state_q != CIMS_ST_RUN) begin
            mode_q <= mode_d;
        end
    end

    assign is_master = (mode_q == CIMS_MODE_MASTER_SERIAL) || (mode_q == CIMS_MODE_MASTER_UP)
        || (mode_q == CIMS_MODE_MASTER_DOWN);

    // Internal timer; exact 1 MHz instead of the loose on-chip oscillator
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == TICK_W'(TIMER_DIV - 1));

    // Separate cycle count, only for the tick rate check
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_gap_q <= 0;
        end else if (tick_gap_q == TIMER_DIV - 1) begin
            tick_gap_q <= 0;
        end else begin
            tick_gap_q <= tick_gap_q + 1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_cnt_q <= '0;
            pass_q <= '0;
        end else if (state_q == CIMS_ST_INIT && tick) begin
            init_cnt_q <= init_cnt_q + 1'b1;
            if (&init_cnt_q) begin
                pass_q <= pass_q + 1'b1;
            end
        end
    end
    // Master needs four passes, others one
    assign timeout_done = tick && (&init_cnt_q)
        && (!is_master || pass_q == 2'(MASTER_PASSES - 1));

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= CIMS_ST_INIT;
        end else begin
            unique case (state_q)
                CIMS_ST_INIT: if (timeout_done) begin
                    state_q <= CIMS_ST_CLEAR;
                end
                CIMS_ST_CLEAR: if (clr_cnt_q == CLR_W'(CLEAR_CYCLES - 1)) begin
                    state_q <= CIMS_ST_WAIT_RESET;
                end
                CIMS_ST_WAIT_RESET: if (i_ext_reset_n) begin
                    state_q <= CIMS_ST_CONFIG;
                end
                CIMS_ST_CONFIG: if (i_config_loaded) begin
                    state_q <= CIMS_ST_RUN;
                end
                CIMS_ST_RUN: state_q <= CIMS_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clr_cnt_q <= '0;
        end else if (state_q == CIMS_ST_CLEAR) begin
            clr_cnt_q <= clr_cnt_q + 1'b1;
        end else begin
            clr_cnt_q <= '0;
        end
    end

    // Power-down is only honoured once the supply has settled
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= i_powerdown_req && state_q != CIMS_ST_INIT;
        end
    end
    assign o_powerdown = pd_q;

    // Master config clock toggles every system clock, half the system clock rate
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            config_clock_q <= 1'b0;
        end else if (state_q == CIMS_ST_CONFIG && is_master) begin
            config_clock_q <= !config_clock_q;
        end else begin
            config_clock_q <= 1'b0;
        end
    end
    assign o_config_clock_oe = is_master && (state_q == CIMS_ST_CONFIG);
    assign o_config_clock_o = config_clock_q;

    assign o_user_out_disable = (state_q != CIMS_ST_RUN);
    assign o_user_pullup = (state_q != CIMS_ST_RUN);
    assign o_clear_mem = (state_q == CIMS_ST_CLEAR);
    // Open drain: pulled low until init and clear are over
    assign o_init_ready_n_o = 1'b0;
    assign o_init_ready_n_oe = (state_q == CIMS_ST_INIT) || (state_q == CIMS_ST_CLEAR);
    assign o_mode = mode_q;
    assign o_config_active = (state_q == CIMS_ST_CONFIG);
    assign o_config_done = (state_q == CIMS_ST_RUN);

    // Slave/peripheral config clock input goes to the loader, not used here
    cims_osc_ctrl u_osc (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_osc_enable(i_osc_enable),
        .i_osc_div2(i_osc_div2),
        .i_osc_amp(i_osc_amp),
        .i_config_done(o_config_done),
        .o_osc_run(o_osc_run),
        .o_osc_clk(o_osc_clk),
        .o_osc_io_user(o_osc_io_user)
    );

    sequence s_init_end;
        state_q == CIMS_ST_INIT ##1 state_q == CIMS_ST_CLEAR;
    endsequence

    chk_pd_blocked: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_q == CIMS_ST_INIT |=> !o_powerdown)
        else $error("power-down honoured during time-out");
    chk_io_safe: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_q != CIMS_ST_RUN |-> o_user_out_disable && o_user_pullup)
        else $error("user outputs not safe before run");
    chk_timeout_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_init_end |-> init_cnt_q == '0 && pass_q == (is_master ? 2'h0 : 2'h1))
        else $error("time-out length wrong for mode");
    chk_tick_rate: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        tick == (tick_gap_q == TIMER_DIV - 1))
        else $error("timer tick too frequent");
    chk_mode_decode: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_q == CIMS_ST_INIT && {i_mode_select_pin_0, i_mode_select_pin_1, i_mode_select_pin_2} == 3'h7
        |=> o_mode == CIMS_MODE_SLAVE)
        else $error("slave code decoded wrongly");
    chk_clk_dir: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_config_clock_oe |-> is_master)
        else $error("config clock driven in non-master mode");
    chk_ready_pin: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_init_end |-> o_init_ready_n_oe ##1 o_clear_mem)
        else $error("ready pin released before clear");
    chk_reset_wait: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        state_q == CIMS_ST_WAIT_RESET && !i_ext_reset_n |=> state_q == CIMS_ST_WAIT_RESET)
        else $error("configuration entered while external reset low");
endmodule
`default_nettype wire

//--- cims_cfg_src.sv
// External configuration source facing the block.
// Assumes the bench hands it the pulled-up ready pin level.
`timescale 1ns/10ps
`default_nettype none
module cims_cfg_src (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_init_pin,
    input wire logic i_config_active,
    input wire logic i_slave_side,
    input wire logic [3:0] i_hold,
    input wire logic [3:0] i_load_dly,
    output logic o_ext_reset_n,
    output logic o_config_loaded,
    output logic o_config_clock
);
    int cnt;
    always @(negedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 0;
            o_ext_reset_n <= 1'b0;
            o_config_loaded <= 1'b0;
            o_config_clock <= 1'b0;
        end else begin
            o_config_loaded <= 1'b0;
            o_config_clock <= 1'b0;
            // External reset held low until i_hold+1 cycles after ready pin released
            if (i_init_pin && !o_ext_reset_n) begin
                cnt <= cnt + 1;
                if (cnt == i_hold) begin
                    o_ext_reset_n <= 1'b1;
                    cnt <= 0;
                end
            end else if (i_config_active) begin
                cnt <= cnt + 1;
                o_config_clock <= i_slave_side & ~o_config_clock;
                if (cnt == i_load_dly) begin
                    o_config_loaded <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test_cims_top.sv
// Self-checking bench for the initialization and mode select block.
// Assumes the package constants and the source model beside it.
`timescale 1ns/10ps
`default_nettype none
module test_cims_top;
    import cims_pkg::*;
    localparam int W = 4;
    localparam int DIV = 2;
    localparam int CLR = 4;
    logic clk, rst_n, m0, m1, m2, pd_req, osc_en, div2, amp, slv, ext_rst_n, loaded, config_clock_in;
    logic dis, pull, pd, clr_mem, rdy_o, rdy_oe, config_clock_oe, config_clock_o, active, done, osc_run, osc_clk, io_user;
    logic e, c0, mst, pa, dq;
    logic [2:0] code;
    logic [3:0] hold, load_dly;
    cims_mode_e mode;
    cims_mode_e mtab [8] = '{CIMS_MODE_MASTER_SERIAL, CIMS_MODE_MASTER_UP, CIMS_MODE_UNDEFINED,
        CIMS_MODE_MASTER_DOWN, CIMS_MODE_UNDEFINED, CIMS_MODE_PERIPHERAL, CIMS_MODE_UNDEFINED, CIMS_MODE_SLAVE};
    int error_cnt, n_tests, seed, n, ex;
    wire logic init_pin = rdy_oe ? rdy_o : 1'b1;
    cims_top #(.INIT_CNT_W(W), .TIMER_DIV(DIV), .CLEAR_CYCLES(CLR)) cims_top_i (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_ext_reset_n(ext_rst_n), .i_mode_select_pin_0(m0),
        .i_mode_select_pin_1(m1), .i_mode_select_pin_2(m2), .i_powerdown_req(pd_req),
        .i_config_clock_in(config_clock_in), .i_config_loaded(loaded), .i_osc_enable(osc_en), .i_osc_div2(div2),
        .i_osc_amp(amp), .o_user_out_disable(dis), .o_user_pullup(pull), .o_powerdown(pd),
        .o_clear_mem(clr_mem), .o_init_ready_n_o(rdy_o), .o_init_ready_n_oe(rdy_oe), .o_mode(mode),
        .o_config_clock_oe(config_clock_oe), .o_config_clock_o(config_clock_o), .o_config_active(active),
        .o_config_done(done), .o_osc_run(osc_run), .o_osc_clk(osc_clk), .o_osc_io_user(io_user));
    cims_cfg_src cims_cfg_src_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_init_pin(init_pin),
        .i_config_active(active), .i_slave_side(slv), .i_hold(hold), .i_load_dly(load_dly),
        .o_ext_reset_n(ext_rst_n), .o_config_loaded(loaded), .o_config_clock(config_clock_in));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial begin
        seed = 32'h2e42d3d3;
        {rst_n, m0, m1, m2, pd_req, osc_en, div2, amp, slv, hold, load_dly} = '0;
        error_cnt = 0;
        n_tests = 0;
        for (int i = 0; i < 8; i++) begin
            rst_n = 1'b0;
            {m0, m1, m2} = i[2:0];
            {osc_en, div2, amp} = {2'($random(seed)), 1'b0};
            {hold, load_dly} = 8'($random(seed));
            repeat (8) @(negedge clk);
            chk("mode_rst", mode, CIMS_MODE_UNDEFINED);
            rst_n = 1'b1;
            n = 0;
            // Tolerance of one tick plus one cycle, tick phase is not pinned
            ex = (1 << W) * DIV * ((i == 0 || i == 1 || i == 3) ? 4 : 1);
            while (rdy_oe && !clr_mem && n < 1000) begin
                pd_req = 1'($random(seed));
                @(negedge clk);
                n++;
                if (!clr_mem)
                    chk("pd_init", pd, 0);
                chk("hold_io", {dis, pull}, 2'b11);
            end
            chk("init_len", n > ex - DIV - 2 && n < ex + DIV + 2, 1);
            n = 0;
            while (clr_mem && n < 100) begin
                chk("rdy_clr", init_pin, 0);
                @(negedge clk);
                n++;
            end
            chk("clr_len", n, CLR);
            chk("rdy_rel", init_pin, 1);
            code = 3'($random(seed));
            mst = code == 0 || code == 1 || code == 3;
            slv = !mst;
            {m0, m1, m2} = code;
            n = 0;
            while (!active && n < 40) begin
                @(negedge clk);
                n++;
            end
            chk("rst_gate", n > hold && active, 1);
            chk("mode", mode, mtab[code]);
            chk("config_clock_dir", config_clock_oe, mst);
            chk("osc", {osc_run, io_user, osc_clk, dis}, {osc_en, !osc_en, 2'b01});
            c0 = config_clock_o;
            {m0, m1, m2} = ~code;
            @(negedge clk);
            chk("frozen", mode, mtab[code]);
            chk("config_clock_run", config_clock_o, mst & !c0);
            n = 0;
            while (!done && n < 40) begin
                @(negedge clk);
                n++;
            end
            chk("run", {done, dis, pull}, 3'b100);
            osc_en = 1'b1;
            div2 = 1'($random(seed));
            repeat (2) @(negedge clk);
            {pa, dq} = 2'b00;
            repeat (16) begin
                {amp, pd_req} = 2'($random(seed));
                @(negedge clk);
                e = div2 ? dq : amp;
                dq = dq ^ (amp & !pa);
                pa = amp;
                chk("osc_clk", osc_clk, e);
                chk("pd_run", pd, pd_req);
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
